// [rca_receive_channel_assigner.sv]
// Behaviour
// - 32 links, each deserialised on own clock
// - simultaneous bytes served lowest link first
// - channelised slot mapped via link/slot table
// - unchannelised link mapped by link only
// - per-channel loopback replaces line bytes
// - bit counter, shifter, holding register, request
// - clock gap restarts bit and slot counters of channelised links
// - unchannelised links keep slot, gap counters at zero
// - requests synchronised; idle when none pending
// - every fourth cycle is a null cycle
// - 1024-word provisioning RAM, channel plus enable
// - looped transmit bytes enter 64-entry queue
// - idle or looped slot takes queued byte
// - 128 channels, flags, destuff, CRC16/CRC32
// - end of frame appends packet status
// - transparent channel passes bytes unchanged
// - over-length packet stops further checks
// - abort squelches checks; CRC needs alignment
// - channel state read, processed, written back
// - indirect host access in null cycles; reset
// - flag delimits frames; stuffed zeros removed
// - seven ones abort the packet
// - short packet under four or six bytes
// - two or four byte check field
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rca_receive_channel_assigner
  import rca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] line_clk,
  input wire logic [31:0] line_data,
  input wire logic tx_valid,
  input wire logic [6:0] tx_chan,
  input wire logic [7:0] tx_data,
  output logic out_valid,
  output logic out_eop,
  output logic [6:0] out_chan,
  output logic [7:0] out_data,
  output logic [4:0] out_status
);

  typedef struct packed {
    rca_link_t [LINKS-1:0] lnk;
    logic [1:0] phase;
    logic a_valid;
    logic a_null;
    logic a_unch;
    logic [4:0] a_link;
    logic [4:0] a_ts;
    logic [7:0] a_data;
    logic b_valid;
    logic b_null;
    logic [6:0] b_chan;
    logic [7:0] b_data;
    logic o_valid;
    logic o_eop;
    logic [6:0] o_chan;
    logic [7:0] o_data;
    logic [4:0] o_status;
    logic [7:0] gap_thresh;
    logic [31:0] unch;
    logic [15:0] max_len;
    logic prov_wr;
    logic prov_rd;
    logic [9:0] prov_addr;
    logic [7:0] prov_wdata;
    logic [7:0] prov_rdata;
    logic ch_wr;
    logic ch_rd;
    logic [6:0] ch_sel;
    rca_cfg_t ch_wcfg;
    rca_cfg_t ch_rcfg;
    logic [6:0] lb_wp;
    logic [6:0] lb_rp;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rca_state_t;

  rca_state_t st;
  rca_state_t nx;

  logic [7:0] prov_ram [PROV_WORDS];
  rca_cfg_t cfg_ram [CHANS];
  rca_chst_t chst_ram [CHANS];
  logic [14:0] lb_mem [LB_DEPTH];

  logic prov_we;
  logic cfg_we;
  logic chst_we;
  logic [6:0] chst_wa;
  rca_chst_t chst_wd;
  logic lb_we;

  function automatic logic [31:0] crc_byte(input logic [31:0] crc_in, input logic [7:0] d,
                                           input logic is32);
    logic [31:0] c;
    logic fb;
    c = crc_in;
    fb = 1'b0;
    // first arrived bit sits in bit 7
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[0] ^ d[i];
      c = {1'b0, c[31:1]} ^ (fb ? (is32 ? CRC32_POLY : CRC16_POLY) : 32'h0000_0000);
      if (!is32)
      begin
        c[31:16] = 16'h0000;
      end
    end
    return c;
  endfunction : crc_byte

  function automatic rca_hres_t hdlc_byte(input rca_chst_t s_in, input rca_cfg_t c,
                                          input logic [7:0] d, input logic [15:0] maxlen);
    rca_hres_t r;
    rca_chst_t s;
    logic b;
    logic push;
    logic aligned;
    logic [7:0] ob;
    logic [15:0] minlen;
    r = '0;
    s = s_in;
    b = 1'b0;
    push = 1'b0;
    aligned = 1'b0;
    ob = 8'h00;
    minlen = c.crc32 ? MIN_LEN32 : MIN_LEN16;
    if (c.transparent)
    begin
      r.valid = 1'b1;
      r.data = d;
    end
    else
    begin
      for (int i = 7; i >= 0; i--)
      begin
        b = d[i];
        push = 1'b0;
        if (b)
        begin
          if (s.ones == 3'h6)
          begin
            // inactive frames never report; over-length ones are already out of frame
            if (s.inframe && (s.len != 16'h0000 || s.cnt > 4'h6))
            begin
              r.eop = 1'b1;
              r.status = 5'h00;
              r.status[ST_ABORT] = 1'b1;
            end
            s.inframe = 1'b0;
            s.ones = 3'h7;
          end
          else if (s.ones != 3'h7)
          begin
            s.ones = s.ones + 3'h1;
            push = (s.ones <= 3'h5);
          end
        end
        else
        begin
          if (s.ones == 3'h6)
          begin
            if (s.inframe && (s.len != 16'h0000 || s.cnt > 4'h6))
            begin
              // six flag bits sit at the young end of the window
              aligned = (s.cnt == 4'hE);
              if (aligned)
              begin
                ob = s.win[13:6];
                r.valid = 1'b1;
                r.data = ob;
                s.crc = crc_byte(s.crc, ob, c.crc32);
                s.len = s.len + 16'h0001;
              end
              r.eop = 1'b1;
              r.status = 5'h00;
              if (s.len > maxlen)
              begin
                r.status[ST_MAXLEN] = 1'b1;
              end
              else
              begin
                r.status[ST_ALIGN] = !aligned;
                r.status[ST_SHORT] = (s.len < minlen);
                r.status[ST_CRC] = aligned && c.crc_en &&
                  (c.crc32 ? (s.crc != CRC32_GOOD) : (s.crc[15:0] != CRC16_GOOD));
              end
            end
            s.inframe = 1'b1;
            s.win = 14'h0000;
            s.cnt = 4'h0;
            s.len = 16'h0000;
            s.crc = c.crc32 ? CRC32_INIT : CRC16_INIT;
          end
          else if (s.ones != 3'h5)
          begin
            push = 1'b1;
          end
          s.ones = 3'h0;
        end
        if (push && s.inframe)
        begin
          if (s.cnt == 4'hE)
          begin
            ob = s.win[13:6];
            r.valid = 1'b1;
            r.data = ob;
            s.crc = crc_byte(s.crc, ob, c.crc32);
            s.len = s.len + 16'h0001;
            s.win = {7'h00, s.win[5:0], b};
            s.cnt = 4'h7;
            if (s.len > maxlen)
            begin
              r.eop = 1'b1;
              r.status = 5'h00;
              r.status[ST_MAXLEN] = 1'b1;
              s.inframe = 1'b0;
            end
          end
          else
          begin
            s.win = {s.win[12:0], b};
            s.cnt = s.cnt + 4'h1;
          end
        end
      end
    end
    r.st = s;
    return r;
  endfunction : hdlc_byte

  function automatic logic [5:0] first_req(input logic [31:0] req);
    logic [5:0] f;
    f = 6'h00;
    for (int i = LINKS - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        f = {1'b1, 5'(i)};
      end
    end
    return f;
  endfunction : first_req

  rca_link_t l;
  logic [31:0] reqs;
  logic [5:0] pick;
  logic gnt;
  logic edge_seen;
  logic [7:0] prov_word;
  rca_cfg_t a_cfg;
  rca_cfg_t tx_cfg;
  logic lb_avail;
  logic lb_full;
  logic take_lb;
  rca_hres_t hres;
  logic apb_wr;

  always_comb
  begin
    nx = st;
    l = '0;
    reqs = 32'h0000_0000;
    edge_seen = 1'b0;
    prov_we = 1'b0;
    cfg_we = 1'b0;
    chst_we = 1'b0;
    chst_wa = st.b_chan;
    chst_wd = CHST_INIT;
    lb_we = 1'b0;
    hres = '0;
    apb_wr = psel && penable && st.pready && pwrite;

    nx.phase = st.phase + 2'h1;
    for (int i = 0; i < LINKS; i++)
    begin
      reqs[i] = st.lnk[i].req;
    end
    pick = first_req(reqs);
    gnt = pick[5] && (st.phase != NULL_PHASE);

    for (int i = 0; i < LINKS; i++)
    begin
      l = st.lnk[i];
      l.clk_s1 = line_clk[i];
      l.clk_s2 = st.lnk[i].clk_s1;
      l.clk_s3 = st.lnk[i].clk_s2;
      l.dat_s1 = line_data[i];
      l.dat_s2 = st.lnk[i].dat_s1;
      edge_seen = st.lnk[i].clk_s2 && !st.lnk[i].clk_s3;
      if (gnt && pick[4:0] == 5'(i))
      begin
        l.req = 1'b0;
      end
      if (edge_seen)
      begin
        l.shift = {st.lnk[i].shift[6:0], st.lnk[i].dat_s2};
        l.bits = st.lnk[i].bits + 3'h1;
        if (st.lnk[i].bits == 3'h7)
        begin
          l.hold = {st.lnk[i].shift[6:0], st.lnk[i].dat_s2};
          l.hold_ts = st.lnk[i].ts;
          l.req = 1'b1; // new byte wins over a same-cycle grant
          l.ts = st.lnk[i].ts + 5'h01;
        end
      end
      if (st.unch[i])
      begin
        l.ts = 5'h00;
        l.act = 8'h00;
      end
      else if (edge_seen)
      begin
        l.act = 8'h00;
      end
      else if (st.lnk[i].act != st.gap_thresh)
      begin
        l.act = st.lnk[i].act + 8'h01;
        if (l.act == st.gap_thresh)
        begin
          l.bits = 3'h0;
          l.ts = 5'h00;
        end
      end
      nx.lnk[i] = l;
    end

    // stage A: one serviced byte or an idle/null cycle
    nx.a_null = (st.phase == NULL_PHASE);
    nx.a_valid = gnt;
    nx.a_link = pick[4:0];
    nx.a_ts = st.lnk[pick[4:0]].hold_ts;
    nx.a_data = st.lnk[pick[4:0]].hold;
    nx.a_unch = st.unch[pick[4:0]];

    // stage B: channel lookup and loopback substitution
    prov_word = prov_ram[{st.a_link, st.a_unch ? 5'h00 : st.a_ts}];
    a_cfg = cfg_ram[prov_word[6:0]];
    lb_avail = (st.lb_wp != st.lb_rp);
    lb_full = (st.lb_wp[6] != st.lb_rp[6]) && (st.lb_wp[5:0] == st.lb_rp[5:0]);
    // idle cycles drain the queue too; a looped channel needs no line traffic
    take_lb = !st.a_null && lb_avail &&
      (!st.a_valid || !prov_word[7] || a_cfg.loopback);
    nx.b_null = st.a_null;
    if (take_lb)
    begin
      nx.b_valid = 1'b1;
      nx.b_chan = lb_mem[st.lb_rp[5:0]][14:8];
      nx.b_data = lb_mem[st.lb_rp[5:0]][7:0];
      nx.lb_rp = st.lb_rp + 7'h01;
    end
    else
    begin
      // line bytes of a looped channel are dropped
      nx.b_valid = st.a_valid && prov_word[7] && !a_cfg.loopback;
      nx.b_chan = prov_word[6:0];
      nx.b_data = st.a_data;
    end

    tx_cfg = cfg_ram[tx_chan];
    if (tx_valid && tx_cfg.loopback && !lb_full)
    begin
      lb_we = 1'b1;
      nx.lb_wp = st.lb_wp + 7'h01;
    end

    // stage C: per-channel frame processing
    nx.o_valid = 1'b0;
    nx.o_eop = 1'b0;
    if (st.b_valid)
    begin
      hres = hdlc_byte(chst_ram[st.b_chan], cfg_ram[st.b_chan], st.b_data, st.max_len);
      chst_we = 1'b1;
      chst_wd = hres.st;
      nx.o_valid = hres.valid;
      nx.o_eop = hres.eop;
      nx.o_chan = st.b_chan;
      nx.o_data = hres.data;
      nx.o_status = hres.status;
    end

    // host indirect operations use null slots only
    if (st.a_null)
    begin
      if (st.prov_wr)
      begin
        prov_we = 1'b1;
      end
      nx.prov_rdata = prov_ram[st.prov_addr];
      nx.prov_wr = 1'b0;
      nx.prov_rd = 1'b0;
    end
    // b stage is empty one cycle after the null slot
    if (st.b_null)
    begin
      if (st.ch_wr)
      begin
        cfg_we = 1'b1;
        chst_we = 1'b1;
        chst_wa = st.ch_sel;
        chst_wd = CHST_INIT;
      end
      nx.ch_rcfg = cfg_ram[st.ch_sel];
      nx.ch_wr = 1'b0;
      nx.ch_rd = 1'b0;
    end

    // APB slave: answer one cycle after setup
    nx.pready = psel && !penable;
    nx.pslverr = 1'b0;
    if (psel && !penable)
    begin
      unique case (paddr)
        ADDR_GAP_THRESH: nx.prdata = {24'h00_0000, st.gap_thresh};
        ADDR_UNCH_MASK: nx.prdata = st.unch;
        ADDR_MAX_LEN: nx.prdata = {16'h0000, st.max_len};
        ADDR_PROV_CMD: nx.prdata = {st.prov_wr | st.prov_rd, 23'h00_0000, st.prov_rdata};
        ADDR_CHAN_CMD: nx.prdata = {st.ch_wr | st.ch_rd, 27'h000_0000, st.ch_rcfg};
        ADDR_LB_LEVEL: nx.prdata = {25'h000_0000, st.lb_wp - st.lb_rp};
        ADDR_LINK_REQ: nx.prdata = reqs;
        default:
        begin
          nx.prdata = 32'h0000_0000;
          nx.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_wr && !st.pslverr)
    begin
      unique case (paddr)
        ADDR_GAP_THRESH: nx.gap_thresh = pwdata[7:0];
        ADDR_UNCH_MASK: nx.unch = pwdata;
        ADDR_MAX_LEN: nx.max_len = pwdata[15:0];
        ADDR_PROV_CMD:
        begin
          // a command while one is pending is ignored
          if (!(st.prov_wr || st.prov_rd))
          begin
            nx.prov_addr = pwdata[9:0];
            nx.prov_wdata = {pwdata[PROV_EN_BIT], pwdata[PROV_CHAN_LSB +: 7]};
            nx.prov_wr = pwdata[CMD_WRITE_BIT];
            nx.prov_rd = pwdata[CMD_READ_BIT] && !pwdata[CMD_WRITE_BIT];
          end
        end
        ADDR_CHAN_CMD:
        begin
          if (!(st.ch_wr || st.ch_rd))
          begin
            nx.ch_sel = pwdata[6:0];
            nx.ch_wcfg = pwdata[CHAN_CFG_LSB +: 4];
            nx.ch_wr = pwdata[CMD_WRITE_BIT];
            nx.ch_rd = pwdata[CMD_READ_BIT] && !pwdata[CMD_WRITE_BIT];
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.gap_thresh <= RST_GAP_THRESH;
      st.unch <= RST_UNCH_MASK;
      st.max_len <= RST_MAX_LEN;
    end
    else
    begin
      st <= nx;
    end
  end

  // memories carry no reset; a channel write clears its state
  always_ff @(posedge pclk)
  begin
    if (prov_we)
    begin
      prov_ram[st.prov_addr] <= st.prov_wdata;
    end
    if (cfg_we)
    begin
      cfg_ram[st.ch_sel] <= st.ch_wcfg;
    end
    if (chst_we)
    begin
      chst_ram[chst_wa] <= chst_wd;
    end
    if (lb_we)
    begin
      lb_mem[st.lb_wp[5:0]] <= {tx_chan, tx_data};
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign out_valid = st.o_valid;
  assign out_eop = st.o_eop;
  assign out_chan = st.o_chan;
  assign out_data = st.o_data;
  assign out_status = st.o_status;

endmodule : rca_receive_channel_assigner
`default_nettype wire

// [rca_pkg.sv]
`default_nettype none
package rca_pkg;

  localparam int LINKS = 32;
  localparam int CHANS = 128;
  localparam int PROV_WORDS = 1024;
  localparam int LB_DEPTH = 64;

  // register byte addresses
  localparam logic [11:0] ADDR_GAP_THRESH = 12'h000;
  localparam logic [11:0] ADDR_UNCH_MASK = 12'h004;
  localparam logic [11:0] ADDR_MAX_LEN = 12'h008;
  localparam logic [11:0] ADDR_PROV_CMD = 12'h00C;
  localparam logic [11:0] ADDR_CHAN_CMD = 12'h010;
  localparam logic [11:0] ADDR_LB_LEVEL = 12'h014;
  localparam logic [11:0] ADDR_LINK_REQ = 12'h018;

  // command register fields
  localparam int CMD_WRITE_BIT = 31;
  localparam int CMD_READ_BIT = 30;
  localparam int PROV_EN_BIT = 17;
  localparam int PROV_CHAN_LSB = 10;
  localparam int CHAN_CFG_LSB = 8;

  // reset values
  localparam logic [7:0] RST_GAP_THRESH = 8'h40;
  localparam logic [31:0] RST_UNCH_MASK = 32'h0000_0000;
  localparam logic [15:0] RST_MAX_LEN = 16'h0600;

  localparam logic [1:0] NULL_PHASE = 2'h3;

  localparam logic [31:0] CRC16_POLY = 32'h0000_8408;
  localparam logic [31:0] CRC32_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC16_INIT = 32'h0000_FFFF;
  localparam logic [31:0] CRC32_INIT = 32'hFFFF_FFFF;
  localparam logic [15:0] CRC16_GOOD = 16'hF0B8;
  localparam logic [31:0] CRC32_GOOD = 32'hDEBB_20E3;
  localparam logic [15:0] MIN_LEN16 = 16'h0004;
  localparam logic [15:0] MIN_LEN32 = 16'h0006;

  // packet status bit positions
  localparam int ST_CRC = 0;
  localparam int ST_ALIGN = 1;
  localparam int ST_MAXLEN = 2;
  localparam int ST_ABORT = 3;
  localparam int ST_SHORT = 4;

  typedef struct packed {
    logic loopback;
    logic crc_en;
    logic crc32;
    logic transparent;
  } rca_cfg_t;

  typedef struct packed {
    logic inframe;
    logic [2:0] ones;
    logic [13:0] win;
    logic [3:0] cnt;
    logic [31:0] crc;
    logic [15:0] len;
  } rca_chst_t;

  localparam rca_chst_t CHST_INIT = '{inframe: 1'b0, ones: 3'h0, win: 14'h0000,
    cnt: 4'h0, crc: 32'hFFFF_FFFF, len: 16'h0000};

  typedef struct packed {
    rca_chst_t st;
    logic valid;
    logic eop;
    logic [7:0] data;
    logic [4:0] status;
  } rca_hres_t;

  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic dat_s1;
    logic dat_s2;
    logic [7:0] shift;
    logic [2:0] bits;
    logic [7:0] hold;
    logic [4:0] hold_ts;
    logic req;
    logic [4:0] ts;
    logic [7:0] act;
  } rca_link_t;

endpackage : rca_pkg
`default_nettype wire

// [rca_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module rca_monitor
  import rca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] line_clk,
  input wire logic tx_valid,
  input wire logic out_valid,
  input wire logic out_eop
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // quiet cycles; long enough for a full loopback queue to drain
  logic [7:0] quiet;
  logic [31:0] clk_d;
  logic mapped;
  assign mapped = paddr <= ADDR_LINK_REQ && paddr[1:0] == 2'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet <= 8'h00;
      clk_d <= 32'h0000_0000;
    end
    else
    begin
      clk_d <= line_clk;
      if (tx_valid || line_clk != clk_d)
        quiet <= 8'h00;
      else if (quiet != 8'hFF)
        quiet <= quiet + 8'h01;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  sequence s_three_beats;
    out_valid [*3];
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  a_unmapped_err: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access accepted");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_null_gap: assert property (s_three_beats |=> !out_valid)
    else $error("no null cycle in beat run");
  a_quiet_idle: assert property (quiet > 8'h96 |-> !out_valid && !out_eop)
    else $error("beat without input activity");
endmodule : rca_monitor
bind rca_receive_channel_assigner rca_monitor rca_monitor_inst (.pclk, .presetn, .paddr,
  .psel, .penable, .prdata, .pready, .pslverr, .line_clk, .tx_valid, .out_valid, .out_eop);
`default_nettype wire

// [rca_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rca_line_model (
  output logic [31:0] line_clk,
  output logic [31:0] line_data
);
  initial
  begin
    line_clk = 32'h0;
    line_data = 32'h0;
  end
  // msb first, 5 MHz; clock rests low between bursts so gaps are seen
  task automatic send(input int l, input logic [127:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      line_data[l] = v[i];
      #100 line_clk[l] = 1'b1;
      #100 line_clk[l] = 1'b0;
    end
    // stale data must not look valid
    line_data[l] = ~line_data[l];
  endtask : send
endmodule : rca_line_model
`default_nettype wire

// [tb_rca_receive_channel_assigner.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_rca_receive_channel_assigner;
  import rca_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic tx_valid = 1'b0, pready, pslverr, out_valid, out_eop, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, line_clk, line_data, rd;
  logic [6:0] tx_chan = 7'h00, out_chan;
  logic [7:0] tx_data = 8'h00, out_data, d;
  logic [4:0] out_status;
  logic [14:0] beats[$];
  logic [4:0] stats[$];
  int num_errors = 0, n_checks = 0, cyc = 0, l, maxl = 1536, gn;
  logic [127:0] gv;
  logic [11:0] ra[4] = '{ADDR_GAP_THRESH, ADDR_UNCH_MASK, ADDR_MAX_LEN, 12'h040};
  logic [31:0] rv[4] = '{32'h40, 32'h0, 32'h600, 32'h0};
  always #12.5 pclk = ~pclk;
  rca_receive_channel_assigner rca_receive_channel_assigner_inst (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .line_clk, .line_data,
    .tx_valid, .tx_chan, .tx_data, .out_valid, .out_eop, .out_chan, .out_data, .out_status);
  rca_line_model rca_line_model_inst (.line_clk, .line_data);
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (out_valid === 1'b1)
      beats.push_back({out_chan, out_data});
    if (out_eop === 1'b1)
      stats.push_back(out_status);
    if (cyc == 40000)
    begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_beat(input logic [6:0] c, input logic [7:0] b);
    chk("beat", 32'({c, b}), 32'(beats.pop_front()));
  endtask : chk_beat
  // wait states allowed: the access ends when pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
    do apb(1'b0, a, 32'h0); while (rd[31] !== 1'b0);
  endtask : cmd
  task automatic prov(input int ln, input int s, input int c);
    cmd(ADDR_PROV_CMD, 32'h8000_0000 | 32'((1 << PROV_EN_BIT) | (c << PROV_CHAN_LSB)
      | (ln << 5) | s));
  endtask : prov
  task automatic cfg(input int c, input logic [3:0] cf);
    cmd(ADDR_CHAN_CMD, 32'h8000_0000 | 32'(cf) << CHAN_CFG_LSB | 32'(c));
  endtask : cfg
  // the pause is longer than the gap threshold, so a burst starts at slot 0
  task automatic sendw(input int ln, input logic [127:0] v, input int n);
    rca_line_model_inst.send(ln, v, n);
    repeat (80) @(posedge pclk);
  endtask : sendw
  function automatic logic [4:0] exp_status(int nb, int xb, logic ce, logic c32, logic ab);
    logic [4:0] s;
    s = 5'h00;
    if (nb > maxl)
      s[ST_MAXLEN] = 1'b1;
    else if (ab)
      s[ST_ABORT] = 1'b1;
    else
    begin
      s[ST_SHORT] = nb < (c32 ? 6 : 4);
      s[ST_ALIGN] = xb != 0;
      s[ST_CRC] = ce && xb == 0;
    end
    return s;
  endfunction : exp_status
  // stuffed bits of a body followed by its good 16-bit check field; returns the bit count
  function automatic int good_frame(input logic [31:0] gd, output logic [127:0] v);
    logic [15:0] c;
    logic [47:0] raw;
    int n;
    int ones;
    c = CRC16_INIT[15:0];
    for (int i = 31; i >= 0; i--)
      c = (c >> 1) ^ ((c[0] ^ gd[i]) ? CRC16_POLY[15:0] : 16'h0000);
    c = ~c;
    raw = {gd, 16'h0000};
    // lowest register bit goes out first
    for (int i = 0; i < 16; i++)
      raw[15 - i] = c[i];
    v = '0;
    n = 0;
    ones = 0;
    for (int i = 47; i >= 0; i--)
    begin
      v = {v[126:0], raw[i]};
      n++;
      ones = raw[i] ? ones + 1 : 0;
      if (ones == 5)
      begin
        v = {v[126:0], 1'b0};
        n++;
        ones = 0;
      end
    end
    return n;
  endfunction : good_frame
  // one frame on the unchannelised link, padded with leading zeros to whole bytes
  task automatic hcase(input logic [3:0] cf, input logic [63:0] b, input int n, input logic ab,
                       input logic ok);
    int p;
    logic [4:0] es;
    p = (8 - n % 8) % 8;
    es = ok ? 5'h00 : exp_status(n / 8, n % 8, cf[2], cf[1], ab);
    cfg(40, cf);
    beats.delete();
    stats.delete();
    sendw(5, (128'h7E << (n + 8)) | (128'(b) << 8) | 128'h7E, n + 16 + p);
    chk("eop count", 32'h1, 32'(stats.size()));
    chk("status", 32'(es), 32'(stats.pop_front()));
  endtask : hcase
  initial
  begin
    void'($urandom(34));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i])
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("register", rv[i], rd);
    end
    chk("slverr", 32'h1, 32'(er));
    $display("test registers done");
    apb(1'b1, ADDR_UNCH_MASK, 32'h0000_0030);
    prov(1, 0, 11);
    prov(2, 0, 5);
    prov(2, 1, 9);
    prov(3, 0, 13);
    prov(4, 0, 20);
    prov(5, 0, 40);
    prov(6, 0, 30);
    cmd(ADDR_PROV_CMD, 32'h4000_0041);
    chk("prov word", 32'h89, rd & 32'hFF);
    foreach (ra[i])
      if (i < 4)
        cfg(i == 0 ? 11 : i == 1 ? 5 : i == 2 ? 9 : 13, 4'h1);
    cfg(20, 4'h1);
    cfg(30, 4'h9);
    sendw(2, 16'hA53C, 16);
    chk_beat(7'd5, 8'hA5);
    chk_beat(7'd9, 8'h3C);
    sendw(2, 8'h5A, 8);
    chk_beat(7'd5, 8'h5A);
    sendw(4, 24'h112233, 24);
    for (int i = 0; i < 3; i++)
      chk_beat(7'd20, 8'(8'h11 * (i + 1)));
    fork
      sendw(3, 8'hC3, 8);
      sendw(1, 8'h96, 8);
    join
    chk_beat(7'd11, 8'h96);
    chk_beat(7'd13, 8'hC3);
    $display("test mapping done");
    for (int i = 0; i < 8; i++)
    begin
      l = ($urandom % 2) ? 1 : 3;
      d = 8'($urandom);
      sendw(l, d, 8);
      chk_beat(l == 1 ? 7'd11 : 7'd13, d);
    end
    $display("test random done");
    sendw(6, 8'h77, 8);
    chk("dropped", 32'h0, 32'(beats.size()));
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      tx_valid <= 1'b1;
      tx_chan <= i == 3 ? 7'd11 : 7'd30;
      tx_data <= 8'(8'hE0 + i);
    end
    @(posedge pclk);
    tx_valid <= 1'b0;
    repeat (80) @(posedge pclk);
    chk("looped count", 32'h3, 32'(beats.size()));
    for (int i = 0; i < 3; i++)
      chk_beat(7'd30, 8'(8'hE0 + i));
    $display("test loopback done");
    hcase(4'h0, 64'h18244281, 32, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
      chk_beat(7'd40, 8'(32'h18244281 >> (24 - 8 * i)));
    hcase(4'h0, 64'h1824, 16, 1'b0, 1'b0);
    hcase(4'h6, 64'h182442816699, 48, 1'b0, 1'b0);
    hcase(4'h0, 64'h0C2, 11, 1'b0, 1'b0);
    hcase(4'h4, 64'h182442FF, 32, 1'b1, 1'b0);
    gn = good_frame(32'h18244281, gv);
    hcase(4'h4, 64'(gv), gn, 1'b0, 1'b1);
    apb(1'b1, ADDR_MAX_LEN, 32'h3);
    maxl = 3;
    hcase(4'h4, 64'h1824428166, 40, 1'b0, 1'b0);
    $display("test frames done");
    final_report();
  end
endmodule : tb_rca_receive_channel_assigner
`default_nettype wire
